//--- logic/cfsc_params.svh
`ifndef CFSC_PARAMS_SVH
`define CFSC_PARAMS_SVH

// Clock of the converter side
`define CFSC_CLK_PERIOD_PS     8000

// Serial control word
`define CFSC_WORD_BITS         16
`define CFSC_SEL_BIT           15
`define CFSC_SEL_GAIN          1'h0
`define CFSC_GAIN_LSB          0
`define CFSC_GAIN_MSB          9
`define CFSC_CLAMP_LSB         0
`define CFSC_CLAMP_MSB         3
`define CFSC_POL_BIT           4
`define CFSC_DLY_LSB           5
`define CFSC_DLY_MSB           6

// Reset values
`define CFSC_GAIN_RST          10'h080
`define CFSC_CLAMP_RST         4'h8
`define CFSC_POL_RST           1'h0
`define CFSC_DLY_RST           2'h0

// Gain mapping, tenths of dB, linear in dB over the code range
`define CFSC_GAIN_MIN_TDB      -60
`define CFSC_GAIN_SPAN_TDB     480
`define CFSC_GAIN_CODE_MAX     1023

// Clamp target in LSB: base plus step times code
`define CFSC_CLAMP_BASE        8'h02
`define CFSC_CLAMP_STEP        8'h10

// Pixel latency and extra output delay
`define CFSC_LATENCY           9
`define CFSC_DLY1_PS           5000
`define CFSC_DLY2_PS           10000
`define CFSC_DLY3_PS           13000
`define CFSC_DLY1_CYC          ((`CFSC_DLY1_PS + `CFSC_CLK_PERIOD_PS - 1) / `CFSC_CLK_PERIOD_PS)
`define CFSC_DLY2_CYC          ((`CFSC_DLY2_PS + `CFSC_CLK_PERIOD_PS - 1) / `CFSC_CLK_PERIOD_PS)
`define CFSC_DLY3_CYC          ((`CFSC_DLY3_PS + `CFSC_CLK_PERIOD_PS - 1) / `CFSC_CLK_PERIOD_PS)
`define CFSC_PIPE_DEPTH        12

`endif

//--- logic/cfsc_pkg.sv
package cfsc_pkg;

   typedef struct packed {
      logic [9:0] gain_code;
      logic [3:0] clamp_code;
      logic       pol_high;
      logic [1:0] out_dly;
   } cfsc_cfg_t;

   typedef struct packed {
      logic       valid;
      logic [9:0] data;
   } cfsc_pix_t;

endpackage : cfsc_pkg

//--- logic/cfsc_top.sv
`timescale 1ns/1ps
`include "cfsc_params.svh"

// Overview of operation
// - Ten-bit gain code: all ones is 42 dB, all zeros is -6 dB.
// - Code 0010000000 is 0 dB, 1000100000 is 19.5 dB, 1101001000 is 33.4 dB.
// - Clamp control code sets black level target from 2 to 242 LSB.
// - Clamp code 1000 regulates the black level to 130 LSB.
// - With delay select 0, each pixel word appears exactly 9 converter cycles after its sample.
// - Sample pulses default active low; serial setting selects active high.
// - Serial bits shift on rising serial clock only while load strobe is low.
// - Rising load strobe copies the shifted word into the latch half chosen by its top bit.
// - With more than 16 bits shifted, only the last 16 are kept.
// - Delay select adds 0, 1, 2 or 2 converter cycles (0, 8, 16 or 16 ns) to pixel output.
module cfsc_top (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_b_i,
   // Serial control link
   input  wire logic                 serial_clock_i,
   input  wire logic                 serial_data_i,
   input  wire logic                 serial_load_strobe_i,
   // Sample pulses and converter data
   input  wire logic                 reference_sample_pulse_i,
   input  wire logic                 data_sample_pulse_i,
   input  wire logic [9:0]           converter_data_i,
   // Control outputs
   output logic      [9:0]           gain_code_o,
   output logic signed [9:0]         gain_tenth_db_o,
   output logic      [7:0]           clamp_level_o,
   output logic                      reference_active_o,
   output logic                      data_active_o,
   output cfsc_pkg::cfsc_cfg_t       cfg_o,
   // Pixel output
   output cfsc_pkg::cfsc_pix_t       pixel_o
);
   import cfsc_pkg::*;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------
   // Gain in tenths of dB, straight line through both end codes
   function automatic logic signed [9:0] gain_tdb(input logic [9:0] code);
      int t;
      t = (int'(code) * `CFSC_GAIN_SPAN_TDB) / `CFSC_GAIN_CODE_MAX + `CFSC_GAIN_MIN_TDB;
      return 10'(t);
   endfunction : gain_tdb

   // Clamp target in LSB
   function automatic logic [7:0] clamp_lsb(input logic [3:0] code);
      return `CFSC_CLAMP_BASE + 8'(code) * `CFSC_CLAMP_STEP;
   endfunction : clamp_lsb

   // Extra output delay in whole cycles, least times rounded up
   function automatic logic [1:0] dly_cycles(input logic [1:0] sel);
      case (sel)
         2'h1:    return 2'(`CFSC_DLY1_CYC);
         2'h2:    return 2'(`CFSC_DLY2_CYC);
         2'h3:    return 2'(`CFSC_DLY3_CYC);
         default: return 2'h0;
      endcase
   endfunction : dly_cycles

   // ------------------------------------------------------------
   // Serial clock domain: shift register
   // ------------------------------------------------------------
   logic [`CFSC_WORD_BITS-1:0] shift_word;
   logic [`CFSC_WORD_BITS-1:0] next_shift_word;

   // Older bits fall off the top, so the last 16 survive
   always_comb begin
      next_shift_word = shift_word;
      if (!serial_load_strobe_i) begin
         next_shift_word = {shift_word[`CFSC_WORD_BITS-2:0], serial_data_i};
      end
   end

   always_ff @(posedge serial_clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         shift_word <= '0;
      end else begin
         shift_word <= next_shift_word;
      end
   end

   // ------------------------------------------------------------
   // Converter clock domain: input synchronisers
   // ------------------------------------------------------------
   // Strobe is the handshake for the word: the serial clock is idle
   // while it is high, so the shift word is stable when we take it.
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic [2:0] next_sync_b;
   logic       strobe_prev;
   logic       next_strobe_prev;

   assign next_sync_b      = sync_a;
   assign next_strobe_prev = sync_b[2];

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_a      <= 3'h7;
         sync_b      <= 3'h7;
         strobe_prev <= 1'h1;
      end else begin
         sync_a      <= {serial_load_strobe_i, reference_sample_pulse_i, data_sample_pulse_i};
         sync_b      <= next_sync_b;
         strobe_prev <= next_strobe_prev;
      end
   end

   // ------------------------------------------------------------
   // Control latch
   // ------------------------------------------------------------
   cfsc_cfg_t cfg;
   cfsc_cfg_t next_cfg;
   logic      commit;

   assign commit = sync_b[2] && !strobe_prev;

   // Top bit of the word picks which half of the latch is written
   always_comb begin
      next_cfg = cfg;
      if (commit) begin
         if (shift_word[`CFSC_SEL_BIT] == `CFSC_SEL_GAIN) begin
            next_cfg.gain_code = shift_word[`CFSC_GAIN_MSB:`CFSC_GAIN_LSB];
         end else begin
            next_cfg.clamp_code = shift_word[`CFSC_CLAMP_MSB:`CFSC_CLAMP_LSB];
            next_cfg.pol_high   = shift_word[`CFSC_POL_BIT];
            next_cfg.out_dly    = shift_word[`CFSC_DLY_MSB:`CFSC_DLY_LSB];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg.gain_code  <= `CFSC_GAIN_RST;
         cfg.clamp_code <= `CFSC_CLAMP_RST;
         cfg.pol_high   <= `CFSC_POL_RST;
         cfg.out_dly    <= `CFSC_DLY_RST;
      end else begin
         cfg <= next_cfg;
      end
   end

   // ------------------------------------------------------------
   // Sample pulses and pixel pipeline
   // ------------------------------------------------------------
   logic      ref_act;
   logic      dat_act;
   cfsc_pix_t pipe [`CFSC_PIPE_DEPTH];
   cfsc_pix_t next_pipe [`CFSC_PIPE_DEPTH];
   logic [3:0] tap;

   // Polarity is applied by xor, so a low pulse is active by default
   assign ref_act = sync_b[1] ^ ~cfg.pol_high;
   assign dat_act = sync_b[0] ^ ~cfg.pol_high;

   // Output tap: stage 8 gives 9 edges after the sample, plus the extra delay cycles
   assign tap = 4'(`CFSC_LATENCY - 1) + 4'(dly_cycles(cfg.out_dly));

   always_comb begin
      next_pipe[0].valid = dat_act;
      next_pipe[0].data  = converter_data_i;
      for (int i = 1; i < `CFSC_PIPE_DEPTH; i++) begin
         next_pipe[i] = pipe[i-1];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < `CFSC_PIPE_DEPTH; i++) begin
            pipe[i] <= '0;
         end
      end else begin
         pipe <= next_pipe;
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   logic [9:0]        next_gain_code;
   logic signed [9:0] next_gain_tdb;
   logic [7:0]        next_clamp;
   cfsc_pix_t         next_pixel;

   always_comb begin
      next_gain_code = cfg.gain_code;
      next_gain_tdb  = gain_tdb(cfg.gain_code);
      next_clamp     = clamp_lsb(cfg.clamp_code);
      next_pixel     = pipe[tap];
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         gain_code_o        <= `CFSC_GAIN_RST;
         gain_tenth_db_o    <= '0;
         clamp_level_o      <= '0;
         reference_active_o <= 1'h0;
         data_active_o      <= 1'h0;
         cfg_o              <= '0;
         pixel_o            <= '0;
      end else begin
         gain_code_o        <= next_gain_code;
         gain_tenth_db_o    <= next_gain_tdb;
         clamp_level_o      <= next_clamp;
         reference_active_o <= ref_act;
         data_active_o      <= dat_act;
         cfg_o              <= cfg;
         pixel_o            <= next_pixel;
      end
   end

endmodule : cfsc_top

//--- verification/cfsc_ctrl_model.sv
`timescale 1ns/1ps
// ------
// Timing generator side of the serial link
// ------
module cfsc_ctrl_model (
   // Serial link
   output logic serial_clock_o,
   output logic serial_data_o,
   output logic serial_load_strobe_o
);
   // Clock still and strobe high between words
   initial begin
      serial_clock_o = 1'b0;
      serial_data_o = 1'b0;
      serial_load_strobe_o = 1'b1;
   end
   // MSB first at 48 ns; odd start offset keeps phase loose
   task automatic send(input logic [16:0] w, input int nb);
      #7 serial_load_strobe_o = 1'b0;
      for (int i = nb - 1; i >= 0; i--) begin
         serial_data_o = w[i];
         #24 serial_clock_o = 1'b1;
         #24 serial_clock_o = 1'b0;
      end
      #24 serial_load_strobe_o = 1'b1;
      serial_data_o = ~serial_data_o; // Released line shows no stale bit
   endtask : send
endmodule : cfsc_ctrl_model

//--- verification/cfsc_top_props.sv
`timescale 1ns/1ps
// ------
// Port checker
// ------
module cfsc_top_props (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Inputs watched
   input wire logic serial_load_strobe_i,
   input wire logic reference_sample_pulse_i,
   input wire logic data_sample_pulse_i,
   input wire logic [9:0] converter_data_i,
   // Outputs watched
   input wire logic [9:0] gain_code_o,
   input wire logic signed [9:0] gain_tenth_db_o,
   input wire logic [7:0] clamp_level_o,
   input wire logic reference_active_o,
   input wire logic data_active_o,
   input wire cfsc_pkg::cfsc_cfg_t cfg_o,
   input wire cfsc_pkg::cfsc_pix_t pixel_o
);
   import cfsc_pkg::*;
   logic [1:0] up;
   logic [1:0] next_up;
   // Settle count: history before reset is meaningless
   always_comb next_up = up + {1'b0, up != 2'h3};
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) up <= 2'h0;
      else up <= next_up;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   AST_CLAMP: assert property (up == 2'h3 |->
      clamp_level_o == 8'h02 + {cfg_o.clamp_code, 4'h0}) else $error("clamp level");
   AST_GAIN_END: assert property (gain_code_o inside {10'h3FF, 10'h000} |->
      gain_tenth_db_o == (gain_code_o[0] ? 10'sd420 : -10'sd60)) else $error("gain end");
   AST_GAIN_ZERO: assert property (gain_code_o == 10'h080 |->
      gain_tenth_db_o == 10'sd0) else $error("gain zero dB");
   AST_LAT: assert property (data_active_o && cfg_o.out_dly == 2'h0 |->
      ##9 pixel_o.valid && pixel_o.data == $past(converter_data_i, 10)) else $error("latency");
   AST_DLY_ONE: assert property (data_active_o && cfg_o.out_dly == 2'h1 |->
      ##10 pixel_o.valid) else $error("delay one");
   AST_DLY_TWO: assert property (data_active_o && cfg_o.out_dly[1] |->
      ##11 pixel_o.valid) else $error("delay two");
   AST_POL: assert property (up == 2'h3 && $past(cfg_o.pol_high, 3) == cfg_o.pol_high |->
      data_active_o == ($past(data_sample_pulse_i, 3) == cfg_o.pol_high) &&
      reference_active_o == ($past(reference_sample_pulse_i, 3) == cfg_o.pol_high))
      else $error("pulse polarity");
   AST_COMMIT: assert property (up == 2'h3 && $changed(cfg_o) |->
      $past(serial_load_strobe_i, 4) && !$past(serial_load_strobe_i, 5)) else $error("commit");
   // Main scenarios
   cover property (pixel_o.valid);
   cover property (data_active_o && cfg_o.out_dly == 2'h3);
   cover property (gain_code_o == 10'h3FF);
endmodule : cfsc_top_props
bind cfsc_top cfsc_top_props cfsc_top_props_i (.clk_i, .rst_b_i, .serial_load_strobe_i,
   .reference_sample_pulse_i, .data_sample_pulse_i, .converter_data_i, .gain_code_o,
   .gain_tenth_db_o, .clamp_level_o, .reference_active_o, .data_active_o, .cfg_o, .pixel_o);

//--- verification/cfsc_top_bench.sv
`timescale 1ns/1ps
// ------
// Bench
// ------
module cfsc_top_bench;
   import cfsc_pkg::*;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic reference_sample_pulse_i = 1'b1;
   logic data_sample_pulse_i = 1'b1;
   logic [9:0] converter_data_i = 10'h000;
   logic pol = 1'b0;
   wire serial_clock_i, serial_data_i, serial_load_strobe_i;
   logic [9:0] gain_code_o;
   logic signed [9:0] gain_tenth_db_o;
   logic [7:0] clamp_level_o;
   logic reference_active_o, data_active_o;
   cfsc_cfg_t cfg_o;
   cfsc_pix_t pixel_o;
   int num_errors = 0;
   int checks_done = 0;
   int n;
   always #4 clk_i = ~clk_i;
   cfsc_top cfsc_top_i (.clk_i, .rst_b_i, .serial_clock_i, .serial_data_i, .serial_load_strobe_i,
      .reference_sample_pulse_i, .data_sample_pulse_i, .converter_data_i, .gain_code_o,
      .gain_tenth_db_o, .clamp_level_o, .reference_active_o, .data_active_o, .cfg_o, .pixel_o);
   cfsc_ctrl_model cfsc_ctrl_model_i (.serial_clock_o(serial_clock_i),
      .serial_data_o(serial_data_i), .serial_load_strobe_o(serial_load_strobe_i));
   task automatic close_out;
      if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         num_errors++;
      end
   endtask : chk
   // Word, then six edges to cover the four-edge commit path
   task automatic put(input logic [16:0] w, input int nb);
      cfsc_ctrl_model_i.send(w, nb);
      repeat (6) @(negedge clk_i);
   endtask : put
   // Reference then data pulse; count edges until the pixel word
   task automatic pix(input logic [9:0] d, input int ex);
      @(negedge clk_i) reference_sample_pulse_i = pol;
      @(negedge clk_i) reference_sample_pulse_i = ~pol;
      data_sample_pulse_i = pol;
      converter_data_i = d;
      for (n = 1; n < 20; n++) begin
         @(negedge clk_i) data_sample_pulse_i = ~pol;
         if (pixel_o.valid === 1'b1) break;
      end
      chk("latency", 16'(12 + ex), 16'(n));
      chk("pixel", {6'h00, d}, {6'h00, pixel_o.data});
   endtask : pix
   initial begin
      #50000 num_errors++;
      close_out();
   end
   initial begin
      repeat (2) @(negedge clk_i);
      rst_b_i = 1'b1;
      repeat (3) @(negedge clk_i);
      chk("gain", 16'h0080, gain_code_o);
      chk("tdb", 16'h0000, gain_tenth_db_o);
      chk("clamp", 16'h0082, clamp_level_o);
      put(17'h103FF, 17);
      chk("gain", 16'h03FF, gain_code_o);
      chk("tdb", 16'h01A4, gain_tenth_db_o);
      put(17'h00000, 16);
      chk("tdb", 16'hFFC4, gain_tenth_db_o);
      put(17'h0802F, 16);
      chk("clamp", 16'h00F2, clamp_level_o);
      // Every delay select, polarity flipping; idle level follows only after commit
      for (int i = 0; i < 4; i++) begin
         put({2'b01, 8'h00, i[1:0], i[0], 4'h8}, 16);
         pol = i[0];
         reference_sample_pulse_i = ~pol;
         data_sample_pulse_i = ~pol;
         repeat (14) @(negedge clk_i);
         chk("clamp", 16'h0082, clamp_level_o);
         pix(10'h155 ^ 10'(i), (i == 0) ? 0 : (i == 1) ? 1 : 2);
      end
      close_out();
   end
endmodule : cfsc_top_bench
